// *** src/cbtec_defs.svh ***
// Register offsets, reset values, field positions and codes of the bit timing and capture block
`ifndef CBTEC_DEFS_SVH
`define CBTEC_DEFS_SVH

`define CBTEC_ADDR_W          8
`define CBTEC_DATA_W          8
`define CBTEC_OFF_INT_FLAG    8'h03
`define CBTEC_OFF_ARB_POS     8'h07
`define CBTEC_OFF_ERR_CAPT    8'h08
`define CBTEC_OFF_BTR_PJ      8'h09
`define CBTEC_OFF_BTR_SEG     8'h0A
`define CBTEC_RST_ARB_POS     8'h00
`define CBTEC_RST_ERR_CAPT    8'h00
`define CBTEC_RST_BTR_PJ      8'h00
`define CBTEC_RST_BTR_SEG     8'h67
`define CBTEC_FLAG_BUS_ERR    7
`define CBTEC_FLAG_ARB_LOST   6
`define CBTEC_PRESC_DIV       2
`define CBTEC_DOM_TOLERATE    4'h7
`define CBTEC_ARB_SRR         5'h0B
`define CBTEC_ARB_IDE         5'h0C
`define CBTEC_ARB_RTR_EXT     5'h1F
`define CBTEC_ETYPE_BIT       2'h0
`define CBTEC_ETYPE_FORM      2'h1
`define CBTEC_ETYPE_STUFF     2'h2
`define CBTEC_ETYPE_OTHER     2'h3
`define CBTEC_SEG_SOF         5'h03
`define CBTEC_SEG_ID28_21     5'h02
`define CBTEC_SEG_ID20_18     5'h06
`define CBTEC_SEG_SRR         5'h04
`define CBTEC_SEG_IDE         5'h05
`define CBTEC_SEG_ID17_13     5'h07
`define CBTEC_SEG_ID12_5      5'h0F
`define CBTEC_SEG_ID4_0       5'h0E
`define CBTEC_SEG_RTR         5'h0C
`define CBTEC_SEG_RES1        5'h0D
`define CBTEC_SEG_RES0        5'h09
`define CBTEC_SEG_DLC         5'h0B
`define CBTEC_SEG_DATA        5'h0A
`define CBTEC_SEG_CRC         5'h08
`define CBTEC_SEG_CRC_DELIM   5'h18
`define CBTEC_SEG_ACK_SLOT    5'h19
`define CBTEC_SEG_ACK_DELIM   5'h1B
`define CBTEC_SEG_EOF         5'h1A
`define CBTEC_SEG_INTERMIS    5'h12
`define CBTEC_SEG_ACT_FLAG    5'h11
`define CBTEC_SEG_PAS_FLAG    5'h16
`define CBTEC_SEG_TOL_DOM     5'h13
`define CBTEC_SEG_ERR_DELIM   5'h17
`define CBTEC_SEG_OVL_FLAG    5'h1C

`endif

// *** src/cbtec_pkg.sv ***
// Types shared by the bit timing and capture block
package cbtec_pkg;

	typedef struct packed {
		logic [1:0] jump_width;
		logic [5:0] quantum_prescale;
		logic       triple_sample_select;
		logic [2:0] second_bit_segment;
		logic [3:0] first_bit_segment;
	} cbtec_timing_t;

	typedef enum logic [2:0] {ARB_ID_BASE, ARB_SRR, ARB_IDE, ARB_ID_EXT, ARB_RTR_EXT} cbtec_arb_field_t;

	typedef struct packed {
		cbtec_arb_field_t field;
		logic [4:0]       id_bit;
	} cbtec_arb_pos_t;

	typedef enum logic [1:0] {ERR_BIT, ERR_FORM, ERR_STUFF, ERR_OTHER} cbtec_err_type_t;

	typedef enum logic [4:0] {
		FS_SOF, FS_ID28_21, FS_ID20_18, FS_SRR, FS_IDE, FS_ID17_13, FS_ID12_5, FS_ID4_0,
		FS_RTR, FS_RES1, FS_RES0, FS_DLC, FS_DATA, FS_CRC, FS_CRC_DELIM, FS_ACK_SLOT,
		FS_ACK_DELIM, FS_EOF, FS_INTERMIS, FS_ACT_FLAG, FS_PAS_FLAG, FS_TOL_DOM, FS_ERR_DELIM, FS_OVL_FLAG
	} cbtec_frame_seg_t;

	typedef struct packed {
		cbtec_err_type_t  etype;
		logic             rx_dir;
		cbtec_frame_seg_t error_frame_segment;
	} cbtec_err_evt_t;

	typedef enum {BT_SYNC, BT_SEG1, BT_SEG2} cbtec_bt_state_t;

endpackage : cbtec_pkg

// *** src/cbtec_bit_timer.sv ***
// Time quantum divider, bit segment sequencer, resynchronisation and sampling
`timescale 1ns/1ps
`include "cbtec_defs.svh"

module cbtec_bit_timer
	import cbtec_pkg::*;
(
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          arst_n_i,
	// Configuration and bus level
	input  wire cbtec_timing_t cfg_i,
	input  wire logic          rx_i,
	// Timing outputs
	output logic               tq_tick_o,
	output logic               bit_start_o,
	output logic               sample_o,
	output logic               rx_bit_o
);

	cbtec_bt_state_t state_q;
	logic [6:0]      pc_q;
	logic [4:0]      qc_q;
	logic [2:0]      ext_q;
	logic            resynced_q;
	logic            rx_prev_q;
	logic [1:0]      smp_q;
	logic            tick;
	logic            fall;
	logic [2:0]      jump;
	logic [4:0]      seg1_last;
	logic [4:0]      seg2_last;
	logic [4:0]      q_plus1;

	function automatic logic majority(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction : majority

	// System clock over 2*(prescale+1)
	assign tick      = (pc_q == {cfg_i.quantum_prescale, 1'b1});
	assign fall      = rx_prev_q & ~rx_i;
	assign jump      = {1'b0, cfg_i.jump_width} + 3'h1;
	assign seg1_last = {1'b0, cfg_i.first_bit_segment} + {2'h0, ext_q};
	assign seg2_last = {2'h0, cfg_i.second_bit_segment};
	assign q_plus1   = qc_q + 5'h01;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pc_q <= 7'h00;
		end else begin
			pc_q <= tick ? 7'h00 : pc_q + 7'h01;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_prev_q <= 1'b1;
			smp_q     <= 2'h3;
		end else if (tick) begin
			rx_prev_q <= rx_i;
			smp_q     <= {smp_q[0], rx_i};
		end
	end

	// Sync quantum, then first segment, then second segment
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q    <= BT_SYNC;
			qc_q       <= 5'h00;
			ext_q      <= 3'h0;
			resynced_q <= 1'b0;
		end else if (tick) begin
			case (state_q)
				BT_SYNC: begin
					state_q    <= BT_SEG1;
					qc_q       <= 5'h00;
					ext_q      <= 3'h0;
					resynced_q <= 1'b0;
				end
				BT_SEG1: begin
					if (fall && !resynced_q) begin
						// Late edge: insert delay after sync, capped at jump width plus one
						ext_q      <= (q_plus1 < {2'h0, jump}) ? q_plus1[2:0] : jump;
						resynced_q <= 1'b1;
					end
					if (qc_q == seg1_last) begin
						state_q <= BT_SEG2;
						qc_q    <= 5'h00;
					end else begin
						qc_q <= q_plus1;
					end
				end
				BT_SEG2: begin
					if (fall && !resynced_q && (q_plus1 + {2'h0, jump} > seg2_last)) begin
						state_q <= BT_SYNC;
					end else if (fall && !resynced_q) begin
						qc_q       <= q_plus1 + {2'h0, jump};
						resynced_q <= 1'b1;
					end else if (qc_q == seg2_last) begin
						state_q <= BT_SYNC;
					end else begin
						qc_q <= q_plus1;
					end
				end
				default: state_q <= BT_SYNC;
			endcase
		end
	end

	// Registered strobes and received bit
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tq_tick_o   <= 1'b0;
			bit_start_o <= 1'b0;
			sample_o    <= 1'b0;
			rx_bit_o    <= 1'b1;
		end else begin
			tq_tick_o   <= tick;
			bit_start_o <= tick && (state_q == BT_SYNC);
			sample_o    <= tick && (state_q == BT_SEG1) && (qc_q == seg1_last);
			if (tick && (state_q == BT_SEG1) && (qc_q == seg1_last)) begin
				rx_bit_o <= cfg_i.triple_sample_select ? majority(smp_q[1], smp_q[0], rx_i) : rx_i;
			end
		end
	end

endmodule : cbtec_bit_timer

// *** src/cbtec_core.sv ***
// Register file, arbitration and bus error capture, with the bit timer inside
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "cbtec_defs.svh"

// Overview of operation
// - Quantum clock is the system clock divided by two, then by prescale plus one.
// - A resynchronisation shifts timing by at most jump width plus one quanta.
// - A falling edge in the first segment lengthens it, moving the sample point later; in the second segment it shortens it.
// - Second segment lasts its three-bit field plus one quanta.
// - First segment lasts its four-bit field plus one quanta.
// - A bit is sync quantum, first segment, second segment; rate follows their sum.
// - Single sampling takes the bus at the first edge of the second segment.
// - Triple sampling uses the last two first-segment edges and first second-segment edge.
// - Triple sampling takes the majority of the three samples.
// - Lost arbitration raises its flag and captures the five-bit bit position.
// - Position codes: ID28..18 as 0..10, SRR 11, IDE 12, ID17..0 13..30, RTR 31.
// - Position stays locked and no new flag until software reads it.
// - Reading the interrupt flag register clears arbitration-lost and bus-error flags.
// - A bus error raises its flag and captures type, direction and segment.
// - Error capture stays locked, ignoring new errors, until software reads it.
// - Error capture is read-only, holds the first error since the last read, clears on read.
// - Error type: bit 0, form 1, stuff 2, anything else 3.
// - Direction bit is one for reception errors, zero for transmission errors.
// - Frame segment of the error is a five-bit code from the segment table.
// - Up to seven dominant bits after an error or overload flag are tolerated.
module cbtec_core
	import cbtec_pkg::*;
#(
	parameter int unsigned DOM_LIMIT = 7
)(
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     arst_n_i,
	// Register port
	input  wire logic [`CBTEC_ADDR_W-1:0] addr_i,
	input  wire logic [`CBTEC_DATA_W-1:0] wdata_i,
	input  wire logic                     we_i,
	input  wire logic                     re_i,
	output logic      [`CBTEC_DATA_W-1:0] rdata_o,
	// Bus level from the transceiver
	input  wire logic                     rx_i,
	// Events from the bit stream processor
	input  wire logic                     arb_lost_i,
	input  wire cbtec_arb_pos_t           arb_pos_i,
	input  wire logic                     bus_err_i,
	input  wire cbtec_err_evt_t           err_evt_i,
	input  wire logic                     flag_done_i,
	// Timing strobes
	output logic                          tq_tick_o,
	output logic                          bit_start_o,
	output logic                          sample_o,
	output logic                          rx_bit_o,
	// Status
	output logic                          arb_lost_flag_o,
	output logic                          bus_err_flag_o,
	output logic                          dom_excess_o
);

	initial begin
		if (DOM_LIMIT < 1 || DOM_LIMIT > 14) begin
			$error("DOM_LIMIT must lie between 1 and 14");
		end
	end

	localparam logic [3:0] DOM_MAX = 4'(DOM_LIMIT);

	logic [7:0]    btr_pj_q;
	logic [7:0]    btr_seg_q;
	logic [4:0]    arb_pos_q;
	logic          arb_armed_q;
	logic [7:0]    err_capt_q;
	logic          err_armed_q;
	logic          flag_al_q;
	logic          flag_be_q;
	logic [7:0]    rdata_q;
	logic [3:0]    dom_cnt_q;
	logic          dom_watch_q;
	logic          dom_excess_q;
	cbtec_timing_t timing;
	logic          rd_flags;
	logic          rd_arb;
	logic          rd_err;
	logic          arb_take;
	logic          err_take;
	logic          bt_tick;
	logic          bt_bit_start;
	logic          bt_sample;
	logic          bt_rx_bit;

	// Bit position of the stream processor as arbitration code
	function automatic logic [4:0] arb_code(input cbtec_arb_pos_t p);
		logic [4:0] c;
		c = 5'h00;
		case (p.field)
			ARB_ID_BASE: c = 5'd28 - p.id_bit;
			ARB_SRR:     c = `CBTEC_ARB_SRR;
			ARB_IDE:     c = `CBTEC_ARB_IDE;
			ARB_ID_EXT:  c = 5'd30 - p.id_bit;
			ARB_RTR_EXT: c = `CBTEC_ARB_RTR_EXT;
			default:     c = 5'h00;
		endcase
		return c;
	endfunction : arb_code

	function automatic logic [1:0] type_code(input cbtec_err_type_t t);
		logic [1:0] c;
		c = `CBTEC_ETYPE_OTHER;
		case (t)
			ERR_BIT:   c = `CBTEC_ETYPE_BIT;
			ERR_FORM:  c = `CBTEC_ETYPE_FORM;
			ERR_STUFF: c = `CBTEC_ETYPE_STUFF;
			default:   c = `CBTEC_ETYPE_OTHER;
		endcase
		return c;
	endfunction : type_code

	function automatic logic [4:0] seg_code(input cbtec_frame_seg_t s);
		logic [4:0] c;
		c = `CBTEC_SEG_SOF;
		case (s)
			FS_SOF:       c = `CBTEC_SEG_SOF;
			FS_ID28_21:   c = `CBTEC_SEG_ID28_21;
			FS_ID20_18:   c = `CBTEC_SEG_ID20_18;
			FS_SRR:       c = `CBTEC_SEG_SRR;
			FS_IDE:       c = `CBTEC_SEG_IDE;
			FS_ID17_13:   c = `CBTEC_SEG_ID17_13;
			FS_ID12_5:    c = `CBTEC_SEG_ID12_5;
			FS_ID4_0:     c = `CBTEC_SEG_ID4_0;
			FS_RTR:       c = `CBTEC_SEG_RTR;
			FS_RES1:      c = `CBTEC_SEG_RES1;
			FS_RES0:      c = `CBTEC_SEG_RES0;
			FS_DLC:       c = `CBTEC_SEG_DLC;
			FS_DATA:      c = `CBTEC_SEG_DATA;
			FS_CRC:       c = `CBTEC_SEG_CRC;
			FS_CRC_DELIM: c = `CBTEC_SEG_CRC_DELIM;
			FS_ACK_SLOT:  c = `CBTEC_SEG_ACK_SLOT;
			FS_ACK_DELIM: c = `CBTEC_SEG_ACK_DELIM;
			FS_EOF:       c = `CBTEC_SEG_EOF;
			FS_INTERMIS:  c = `CBTEC_SEG_INTERMIS;
			FS_ACT_FLAG:  c = `CBTEC_SEG_ACT_FLAG;
			FS_PAS_FLAG:  c = `CBTEC_SEG_PAS_FLAG;
			FS_TOL_DOM:   c = `CBTEC_SEG_TOL_DOM;
			FS_ERR_DELIM: c = `CBTEC_SEG_ERR_DELIM;
			FS_OVL_FLAG:  c = `CBTEC_SEG_OVL_FLAG;
			default:      c = `CBTEC_SEG_SOF;
		endcase
		return c;
	endfunction : seg_code

	// Register field layout
	assign timing.jump_width           = btr_pj_q[7:6];
	assign timing.quantum_prescale     = btr_pj_q[5:0];
	assign timing.triple_sample_select = btr_seg_q[7];
	assign timing.second_bit_segment   = btr_seg_q[6:4];
	assign timing.first_bit_segment    = btr_seg_q[3:0];

	assign rd_flags = re_i && (addr_i == `CBTEC_OFF_INT_FLAG);
	assign rd_arb   = re_i && (addr_i == `CBTEC_OFF_ARB_POS);
	assign rd_err   = re_i && (addr_i == `CBTEC_OFF_ERR_CAPT);
	assign arb_take = arb_lost_i && arb_armed_q;
	assign err_take = bus_err_i && err_armed_q;

	cbtec_bit_timer u_bit_timer (
		.clk_i       (clk_i),
		.arst_n_i    (arst_n_i),
		.cfg_i       (timing),
		.rx_i        (rx_i),
		.tq_tick_o   (bt_tick),
		.bit_start_o (bt_bit_start),
		.sample_o    (bt_sample),
		.rx_bit_o    (bt_rx_bit)
	);

	// Timing registers, written by software while off the bus
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			btr_pj_q  <= `CBTEC_RST_BTR_PJ;
			btr_seg_q <= `CBTEC_RST_BTR_SEG;
		end else if (we_i) begin
			if (addr_i == `CBTEC_OFF_BTR_PJ) begin
				btr_pj_q <= wdata_i;
			end
			if (addr_i == `CBTEC_OFF_BTR_SEG) begin
				btr_seg_q <= wdata_i;
			end
		end
	end

	// Arbitration lost capture, locked until read
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			arb_pos_q   <= 5'h00;
			arb_armed_q <= 1'b1;
		end else if (arb_take) begin
			arb_pos_q   <= arb_code(arb_pos_i);
			arb_armed_q <= 1'b0;
		end else if (rd_arb) begin
			arb_armed_q <= 1'b1;
		end
	end

	// Bus error capture, locked until read, cleared by the read
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			err_capt_q  <= `CBTEC_RST_ERR_CAPT;
			err_armed_q <= 1'b1;
		end else if (err_take) begin
			err_capt_q  <= {type_code(err_evt_i.etype), err_evt_i.rx_dir, seg_code(err_evt_i.error_frame_segment)};
			err_armed_q <= 1'b0;
		end else if (rd_err) begin
			err_capt_q  <= 8'h00;
			err_armed_q <= 1'b1;
		end
	end

	// Interrupt flags; a new event wins over the clearing read
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flag_al_q <= 1'b0;
			flag_be_q <= 1'b0;
		end else begin
			if (arb_take) begin
				flag_al_q <= 1'b1;
			end else if (rd_flags) begin
				flag_al_q <= 1'b0;
			end
			if (err_take) begin
				flag_be_q <= 1'b1;
			end else if (rd_flags) begin
				flag_be_q <= 1'b0;
			end
		end
	end

	// Dominant bits after a sent error or overload flag
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dom_cnt_q    <= 4'h0;
			dom_watch_q  <= 1'b0;
			dom_excess_q <= 1'b0;
		end else if (flag_done_i) begin
			dom_cnt_q    <= 4'h0;
			dom_watch_q  <= 1'b1;
			dom_excess_q <= 1'b0;
		end else if (bt_sample && dom_watch_q) begin
			if (bt_rx_bit) begin
				dom_watch_q <= 1'b0;
			end else if (dom_cnt_q == DOM_MAX) begin
				dom_excess_q <= 1'b1;
				dom_watch_q  <= 1'b0;
			end else begin
				dom_cnt_q <= dom_cnt_q + 4'h1;
			end
		end
	end

	// Read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_q <= 8'h00;
		end else if (re_i) begin
			case (addr_i)
				`CBTEC_OFF_INT_FLAG: begin
					rdata_q                      <= 8'h00;
					rdata_q[`CBTEC_FLAG_BUS_ERR]  <= flag_be_q;
					rdata_q[`CBTEC_FLAG_ARB_LOST] <= flag_al_q;
				end
				`CBTEC_OFF_ARB_POS:  rdata_q <= {3'h0, arb_pos_q};
				`CBTEC_OFF_ERR_CAPT: rdata_q <= err_capt_q;
				`CBTEC_OFF_BTR_PJ:   rdata_q <= btr_pj_q;
				`CBTEC_OFF_BTR_SEG:  rdata_q <= btr_seg_q;
				default:             rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign rdata_o         = rdata_q;
	assign tq_tick_o       = bt_tick;
	assign bit_start_o     = bt_bit_start;
	assign sample_o        = bt_sample;
	assign rx_bit_o        = bt_rx_bit;
	assign arb_lost_flag_o = flag_al_q;
	assign bus_err_flag_o  = flag_be_q;
	assign dom_excess_o    = dom_excess_q;

endmodule : cbtec_core

// *** bench/cbtec_chk.sv ***
// Assertion checker for the bit timing and capture block
`timescale 1ns/1ps
`include "cbtec_defs.svh"

module cbtec_chk
	import cbtec_pkg::*;
#(
	parameter int unsigned DOM_LIMIT = 7
)(
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     arst_n_i,
	// Register port
	input  wire logic [`CBTEC_ADDR_W-1:0] addr_i,
	input  wire logic [`CBTEC_DATA_W-1:0] wdata_i,
	input  wire logic                     we_i,
	input  wire logic                     re_i,
	input  wire logic [`CBTEC_DATA_W-1:0] rdata_o,
	// Events
	input  wire logic                     arb_lost_i,
	input  wire logic                     bus_err_i,
	// Timing and status
	input  wire logic                     tq_tick_o,
	input  wire logic                     bit_start_o,
	input  wire logic                     sample_o,
	input  wire logic                     rx_bit_o,
	input  wire logic                     arb_lost_flag_o,
	input  wire logic                     bus_err_flag_o,
	input  wire logic                     dom_excess_o
);
	logic [7:0]  pj_q, seg_q;
	logic        arb_arm_q, err_arm_q, tq_ok_q, bs_ok_q, wr_cfg, rd_arb, rd_err, rd_flag;
	logic [15:0] tq_cnt_q, bs_cnt_q;
	int unsigned q_clk, nom, jmp, s1q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	assign wr_cfg = we_i && (addr_i == `CBTEC_OFF_BTR_PJ || addr_i == `CBTEC_OFF_BTR_SEG);
	assign rd_arb = re_i && addr_i == `CBTEC_OFF_ARB_POS;
	assign rd_err = re_i && addr_i == `CBTEC_OFF_ERR_CAPT;
	assign rd_flag = re_i && addr_i == `CBTEC_OFF_INT_FLAG;
	assign q_clk = 2 * (32'(pj_q[5:0]) + 1);
	assign jmp = 32'(pj_q[7:6]) + 1;
	assign s1q = q_clk * (32'(seg_q[3:0]) + 1);
	assign nom = 3 + 32'(seg_q[3:0]) + 32'(seg_q[6:4]);

	// Shadow of the timing settings
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pj_q  <= `CBTEC_RST_BTR_PJ;
			seg_q <= `CBTEC_RST_BTR_SEG;
		end else if (we_i && addr_i == `CBTEC_OFF_BTR_PJ) begin
			pj_q <= wdata_i;
		end else if (we_i && addr_i == `CBTEC_OFF_BTR_SEG) begin
			seg_q <= wdata_i;
		end
	end

	// Capture arming, a read re-arms even with an event in the read cycle
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			arb_arm_q <= 1'b1;
			err_arm_q <= 1'b1;
		end else begin
			arb_arm_q <= arb_arm_q ? !arb_lost_i : rd_arb;
			err_arm_q <= err_arm_q ? !bus_err_i : rd_err;
		end
	end

	// Clocks since the last strobe, void across a settings change
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tq_cnt_q <= 16'h0000;
			bs_cnt_q <= 16'h0000;
			tq_ok_q  <= 1'b0;
			bs_ok_q  <= 1'b0;
		end else begin
			tq_cnt_q <= tq_tick_o ? 16'h0001 : tq_cnt_q + 16'h0001;
			bs_cnt_q <= bit_start_o ? 16'h0001 : bs_cnt_q + 16'h0001;
			tq_ok_q  <= !wr_cfg && (tq_ok_q || tq_tick_o);
			bs_ok_q  <= !wr_cfg && (bs_ok_q || bit_start_o);
		end
	end

	tq_period_a: assert property (tq_tick_o && tq_ok_q |-> 32'(tq_cnt_q) == q_clk)
		else $error("quantum period wrong");
	bit_len_a: assert property (bit_start_o && bs_ok_q |-> 32'(bs_cnt_q) <= q_clk * (nom + jmp)
		&& 32'(bs_cnt_q) + q_clk * jmp >= q_clk * nom) else $error("bit length out of range");
	sample_pos_a: assert property (sample_o && bs_ok_q |-> 32'(bs_cnt_q) >= s1q
		&& 32'(bs_cnt_q) <= s1q + q_clk * jmp) else $error("sample point misplaced");
	arb_set_a: assert property (arb_lost_i && arb_arm_q |=> arb_lost_flag_o)
		else $error("arbitration flag not set");
	arb_lock_a: assert property ($rose(arb_lost_flag_o) |-> $past(arb_lost_i) && $past(arb_arm_q))
		else $error("arbitration flag raised while locked");
	err_set_a: assert property (bus_err_i && err_arm_q |=> bus_err_flag_o)
		else $error("bus error flag not set");
	err_lock_a: assert property ($rose(bus_err_flag_o) |-> $past(bus_err_i) && $past(err_arm_q))
		else $error("bus error flag raised while locked");
	flag_clear_a: assert property (rd_flag && !arb_lost_i && !bus_err_i |=> !arb_lost_flag_o && !bus_err_flag_o)
		else $error("flags not cleared by read");
	flag_read_a: assert property (rd_flag |=> rdata_o == {$past(bus_err_flag_o), $past(arb_lost_flag_o), 6'h00})
		else $error("flag read data wrong");
	err_clear_a: assert property ((rd_err && !bus_err_i) ##1 !bus_err_i ##1 (rd_err && !bus_err_i)
		|=> rdata_o == 8'h00) else $error("error capture not cleared by read");
	dom_rise_a: assert property ($rose(dom_excess_o) |-> !rx_bit_o)
		else $error("dominant excess without dominant bit");

	cover property (arb_lost_i && arb_arm_q);
	cover property (bus_err_i && err_arm_q);
	cover property ($rose(dom_excess_o));
	cover property (sample_o && seg_q[7]);
endmodule : cbtec_chk

bind cbtec_core cbtec_chk #(.DOM_LIMIT(DOM_LIMIT)) u_chk (.clk_i, .arst_n_i, .addr_i, .wdata_i, .we_i, .re_i,
	.rdata_o, .arb_lost_i, .bus_err_i, .tq_tick_o, .bit_start_o, .sample_o, .rx_bit_o, .arb_lost_flag_o,
	.bus_err_flag_o, .dom_excess_o);

// *** bench/cbtec_can_node.sv ***
// Behavioural model of another node sharing the bus
`timescale 1ns/1ps

module cbtec_can_node #(
	parameter int unsigned BIT_CLKS = 42
)(
	// Clock
	input  wire logic clk_i,
	// Bus level, recessive when released
	output logic      rx_o
);
	initial rx_o = 1'b1;

	// Sends n bits from position n-1 down, then releases the bus
	task automatic send(input logic [7:0] bits, input int unsigned n);
		for (int i = int'(n) - 1; i >= 0; i--) begin
			rx_o <= bits[i];
			repeat (BIT_CLKS) @(posedge clk_i);
		end
		rx_o <= 1'b1;
	endtask : send
endmodule : cbtec_can_node

// *** bench/tb.sv ***
// Self-checking testbench of the bit timing and capture block
`timescale 1ns/1ps
`include "cbtec_defs.svh"

module tb;
	import cbtec_pkg::*;

	localparam int BIT_CLKS = 42;

	logic           clk_i = 1'b0, arst_n_i = 1'b0, we_i = 1'b0, re_i = 1'b0;
	logic           arb_lost_i = 1'b0, bus_err_i = 1'b0, flag_done_i = 1'b0;
	logic [7:0]     addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
	cbtec_arb_pos_t arb_pos_i = '0;
	cbtec_err_evt_t err_evt_i = '0;
	logic           rx_i, tq_tick_o, bit_start_o, sample_o, rx_bit_o, arb_lost_flag_o, bus_err_flag_o, dom_excess_o;
	int             num_errors = 0;
	int             cmp_count = 0;

	always #2.5 clk_i = ~clk_i;

	cbtec_can_node #(.BIT_CLKS(BIT_CLKS)) node (.clk_i, .rx_o(rx_i));

	cbtec_core dut (.clk_i, .arst_n_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .rx_i, .arb_lost_i, .arb_pos_i,
		.bus_err_i, .err_evt_i, .flag_done_i, .tq_tick_o, .bit_start_o, .sample_o, .rx_bit_o, .arb_lost_flag_o,
		.bus_err_flag_o, .dom_excess_o);

	task automatic report_and_stop();
		if (num_errors == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		we_i    <= 1'b1;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		re_i   <= 1'b1;
		@(posedge clk_i);
		re_i <= 1'b0;
		@(negedge clk_i);
		chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, rdata_o});
	endtask : rd

	task automatic arb(input cbtec_arb_field_t f, input logic [4:0] b);
		@(posedge clk_i);
		arb_lost_i <= 1'b1;
		arb_pos_i  <= '{field: f, id_bit: b};
		@(posedge clk_i);
		arb_lost_i <= 1'b0;
	endtask : arb

	task automatic berr(input cbtec_err_evt_t e);
		@(posedge clk_i);
		bus_err_i <= 1'b1;
		err_evt_i <= e;
		@(posedge clk_i);
		bus_err_i <= 1'b0;
	endtask : berr

	function automatic logic sig(input int k);
		return k == 0 ? tq_tick_o : (k == 1 ? bit_start_o : sample_o);
	endfunction : sig

	// Clocks from a pulse of strobe a to the next pulse of strobe b
	task automatic span(input int a, input int b, output int n);
		n = 0;
		do @(negedge clk_i); while (!sig(a));
		do begin
			@(negedge clk_i);
			n++;
		end while (!sig(b));
	endtask : span

	// Starts traffic half a bit after a sample point
	task automatic align();
		do @(negedge clk_i); while (!sample_o);
		repeat (BIT_CLKS / 2) @(posedge clk_i);
	endtask : align

	task automatic pattern(input logic [7:0] p);
		align();
		fork
			node.send(p, 8);
			for (int k = 7; k >= 0; k--) begin
				do @(negedge clk_i); while (!sample_o);
				chk("rx_bit", {15'h0, p[k]}, {15'h0, rx_bit_o});
			end
		join
	endtask : pattern

	task automatic dom_run(input int unsigned n, input logic exp);
		align();
		fork
			node.send(8'h00, n);
			begin
				flag_done_i <= 1'b1;
				@(posedge clk_i);
				flag_done_i <= 1'b0;
			end
		join
		repeat (2 * BIT_CLKS) @(posedge clk_i);
		@(negedge clk_i);
		chk("dom_excess", {15'h0, exp}, {15'h0, dom_excess_o});
	endtask : dom_run

	initial begin : main
		cbtec_arb_field_t af [8] = '{ARB_ID_BASE, ARB_ID_BASE, ARB_ID_BASE, ARB_SRR, ARB_IDE, ARB_ID_EXT,
			ARB_ID_EXT, ARB_RTR_EXT};
		logic [4:0]       ab [8] = '{5'h14, 5'h1C, 5'h12, 5'h00, 5'h00, 5'h11, 5'h00, 5'h00};
		logic [4:0]       ac [8] = '{5'h08, 5'h00, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h1E, 5'h1F};
		cbtec_frame_seg_t fs [6] = '{FS_SOF, FS_ACK_SLOT, FS_EOF, FS_INTERMIS, FS_ACT_FLAG, FS_OVL_FLAG};
		logic [4:0]       fc [6] = '{5'h03, 5'h19, 5'h1A, 5'h12, 5'h11, 5'h1C};
		logic [7:0]       pj [2] = '{8'h00, 8'h02};
		logic [7:0]       sg [2] = '{8'h67, 8'h13};
		int               n;
		int               q;
		repeat (6) @(posedge clk_i);
		arst_n_i <= 1'b1;
		rd(`CBTEC_OFF_ARB_POS, 8'h00);
		rd(`CBTEC_OFF_ERR_CAPT, 8'h00);
		rd(`CBTEC_OFF_INT_FLAG, 8'h00);
		rd(8'h20, 8'h00);
		wr(`CBTEC_OFF_ARB_POS, 8'hFF);
		wr(`CBTEC_OFF_ERR_CAPT, 8'hFF);
		rd(`CBTEC_OFF_ARB_POS, 8'h00);
		rd(`CBTEC_OFF_ERR_CAPT, 8'h00);
		rd(`CBTEC_OFF_BTR_PJ, 8'h00);
		rd(`CBTEC_OFF_BTR_SEG, 8'h67);
		for (int c = 0; c < 2; c++) begin
			wr(`CBTEC_OFF_BTR_PJ, pj[c]);
			wr(`CBTEC_OFF_BTR_SEG, sg[c]);
			rd(`CBTEC_OFF_BTR_PJ, pj[c]);
			rd(`CBTEC_OFF_BTR_SEG, sg[c]);
			q = 2 * (int'(pj[c][5:0]) + 1);
			span(1, 1, n);
			span(0, 0, n);
			chk("quantum", 16'(q), 16'(n));
			span(1, 1, n);
			chk("bit", 16'(q * (3 + int'(sg[c][3:0]) + int'(sg[c][6:4]))), 16'(n));
			span(1, 2, n);
			chk("seg1", 16'(q * (int'(sg[c][3:0]) + 1)), 16'(n));
			span(2, 1, n);
			chk("seg2", 16'(q * (int'(sg[c][6:4]) + 2)), 16'(n));
		end
		pattern(8'hB2);
		wr(`CBTEC_OFF_BTR_SEG, 8'h93);
		pattern(8'h4D);
		wr(`CBTEC_OFF_BTR_SEG, 8'h13);
		for (int i = 0; i < 8; i++) begin
			arb(af[i], ab[i]);
			@(negedge clk_i);
			chk("arb_flag", 16'h0001, {15'h0, arb_lost_flag_o});
			rd(`CBTEC_OFF_INT_FLAG, 8'h40);
			arb(ARB_ID_BASE, 5'h1B);
			@(negedge clk_i);
			chk("arb_flag", 16'h0000, {15'h0, arb_lost_flag_o});
			rd(`CBTEC_OFF_ARB_POS, {3'h0, ac[i]});
		end
		for (int i = 0; i < 6; i++) begin
			berr('{etype: cbtec_err_type_t'(i % 4), rx_dir: i[0], error_frame_segment: fs[i]});
			@(negedge clk_i);
			chk("err_flag", 16'h0001, {15'h0, bus_err_flag_o});
			berr('{etype: ERR_BIT, rx_dir: 1'b0, error_frame_segment: FS_DATA});
			rd(`CBTEC_OFF_INT_FLAG, 8'h80);
			rd(`CBTEC_OFF_ERR_CAPT, {2'(i % 4), i[0], fc[i]});
			rd(`CBTEC_OFF_ERR_CAPT, 8'h00);
		end
		arb(ARB_IDE, 5'h00);
		berr('{etype: ERR_FORM, rx_dir: 1'b1, error_frame_segment: FS_CRC});
		rd(`CBTEC_OFF_INT_FLAG, 8'hC0);
		rd(`CBTEC_OFF_INT_FLAG, 8'h00);
		dom_run(7, 1'b0);
		dom_run(8, 1'b1);
		dom_run(1, 1'b0);
		report_and_stop();
	end

	initial begin : watchdog
		repeat (20000) @(posedge clk_i);
		num_errors++;
		report_and_stop();
	end
endmodule : tb
